// ### design/hcr_consts.svh
// Register offsets, field positions and reset values of the host command block
`ifndef HCR_CONSTS_SVH
`define HCR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define HCR_OFS_CMD       8'h00
`define HCR_OFS_STAT      8'h04
`define HCR_OFS_CTRL      8'h08
`define HCR_OFS_IRQ_STAT  8'h0C
`define HCR_OFS_IRQ_MASK  8'h10

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define HCR_BIT_CMD_REQ   7
`define HCR_VEC_MSB       6
`define HCR_BIT_REQ_STAT  7
`define HCR_BIT_RX_ENABLE 0
`define HCR_BIT_TX_ENABLE 1
`define HCR_BIT_DUAL      2
`define HCR_CTRL_BITS     3
`define HCR_IRQ_ACCEPT    0
`define HCR_IRQ_REQ_RISE  1
`define HCR_IRQ_REFUSED   2
`define HCR_IRQ_BITS      3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HCR_VEC_RESET     7'h32
`define HCR_CTRL_RESET    3'h0
`define HCR_IRQ_RESET     3'h0

`endif

// ### design/hcr_pkg.sv
// Types shared by the host command block modules
package hcr_pkg;

   typedef logic [6:0] hcr_vector_type;
   typedef logic [7:0] hcr_byte_type;

   typedef enum {
      HCR_CMD_IDLE,
      HCR_CMD_WAIT
   } hcr_cmd_state_type;

endpackage : hcr_pkg

// ### design/hcr_if.sv
// Interfaces joining the top of the host command block to its two leaves
`timescale 1ns/10ps

interface hcr_cmd_if;
   import hcr_pkg::*;
   logic           wr;
   hcr_byte_type   wdata;
   logic           core_ack;
   logic           clear;
   logic           flag;
   hcr_vector_type vector;
   logic           accepted;
   logic           refused;
   modport top (output wr, wdata, core_ack, clear, input flag, vector, accepted, refused);
   modport cmd (input wr, wdata, core_ack, clear, output flag, vector, accepted, refused);
endinterface : hcr_cmd_if

interface hcr_req_if;
   logic tx_enable;
   logic rx_enable;
   logic dual;
   logic txe;
   logic rxf;
   logic soft_clear;
   logic part_clear;
   logic req_stat;
   logic host_line;
   logic tx_line;
   logic rx_line;
   logic req_rise;
   modport top (output tx_enable, rx_enable, dual, txe, rxf, soft_clear, part_clear,
                input req_stat, host_line, tx_line, rx_line, req_rise);
   modport req (input tx_enable, rx_enable, dual, txe, rxf, soft_clear, part_clear,
                output req_stat, host_line, tx_line, rx_line, req_rise);
endinterface : hcr_req_if

// ### design/hcr_cmd.sv
// Host command register: request flag, vector field and core acknowledge
`timescale 1ns/10ps
`include "hcr_consts.svh"

module hcr_cmd
   import hcr_pkg::*;
(
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset_n,
   // Link to top
   hcr_cmd_if.cmd    cmd
);

   hcr_cmd_state_type state;
   hcr_vector_type    vector;
   logic              take_wr;

   // Rewrites while a command is pending are dropped so the vector the
   // core is about to take cannot change under it
   assign take_wr      = cmd.wr && (state == HCR_CMD_IDLE);
   assign cmd.refused  = cmd.wr && (state == HCR_CMD_WAIT);
   assign cmd.accepted = cmd.core_ack && (state == HCR_CMD_WAIT);
   assign cmd.flag     = (state == HCR_CMD_WAIT);
   assign cmd.vector   = vector;

   // ----------------------------------------------------------------------
   // Request flag
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         state <= HCR_CMD_IDLE;
      else if (cmd.clear)
         state <= HCR_CMD_IDLE;
      else
      begin
         case (state)
            HCR_CMD_IDLE:
               if (take_wr && cmd.wdata[`HCR_BIT_CMD_REQ])
                  state <= HCR_CMD_WAIT;
            HCR_CMD_WAIT:
               if (cmd.core_ack)
                  state <= HCR_CMD_IDLE;
            default:
               state <= HCR_CMD_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Vector field
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         vector <= `HCR_VEC_RESET;
      else if (cmd.clear)
         vector <= `HCR_VEC_RESET;
      else if (take_wr)
         vector <= cmd.wdata[`HCR_VEC_MSB:0];
   end

endmodule : hcr_cmd

// ### design/hcr_req.sv
// Host request status and the request output lines
`timescale 1ns/10ps
`include "hcr_consts.svh"

module hcr_req
   import hcr_pkg::*;
(
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset_n,
   // Link to top
   hcr_req_if.req    req
);

   logic tx_want;
   logic rx_want;
   logic req_stat;
   logic next_req;
   logic next_tx;
   logic next_rx;
   logic host_line;
   logic tx_line;
   logic rx_line;

   assign tx_want = req.tx_enable && req.txe;
   assign rx_want = req.rx_enable && req.rxf;

   // Partial resets leave the transmit side empty, so the request follows
   // the transmit enable alone
   always_comb
   begin
      if (req.soft_clear)
      begin
         next_tx = 1'b0;
         next_rx = 1'b0;
      end
      else if (req.part_clear)
      begin
         next_tx = req.tx_enable;
         next_rx = 1'b0;
      end
      else
      begin
         next_tx = tx_want;
         next_rx = rx_want;
      end
      next_req = next_tx || next_rx;
   end

   // ----------------------------------------------------------------------
   // Status and lines
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         req_stat  <= 1'b0;
         host_line <= 1'b0;
         tx_line   <= 1'b0;
         rx_line   <= 1'b0;
      end
      else
      begin
         req_stat  <= next_req;
         host_line <= !req.dual && next_req;
         tx_line   <= req.dual && next_tx;
         rx_line   <= req.dual && next_rx;
      end
   end

   assign req.req_stat  = req_stat;
   assign req.host_line = host_line;
   assign req.tx_line   = tx_line;
   assign req.rx_line   = rx_line;
   assign req.req_rise  = next_req && !req_stat;

endmodule : hcr_req

// ### design/hcr_top.sv
// Top of the host command block: register port, core side and request lines
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "hcr_consts.svh"

module hcr_top
   import hcr_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   // Software, individual and stop resets, one-cycle pulses
   input  wire logic        i_soft_reset,
   input  wire logic        i_indiv_reset,
   input  wire logic        i_stop_reset,
   // Host register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // Data path conditions
   input  wire logic        i_receive_full_flag,
   input  wire logic        i_transmit_empty_flag,
   // Core interrupt controller
   input  wire logic        i_core_ack,
   output logic             o_command_pending_flag,
   output logic      [7:0]  o_command_vector_address,
   // Host request lines
   output logic             o_host_request_line,
   output logic             o_transmit_request_line,
   output logic             o_receive_request_line,
   // Interrupt
   output logic             o_irq
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   hcr_cmd_if cmd_link ();
   hcr_req_if req_link ();

   logic [`HCR_CTRL_BITS-1:0] interface_control;
   logic [`HCR_IRQ_BITS-1:0]  irq_stat;
   logic [`HCR_IRQ_BITS-1:0]  irq_mask;
   logic [`HCR_IRQ_BITS-1:0]  irq_set;
   logic [`HCR_IRQ_BITS-1:0]  irq_clr;
   logic                      part_clear;
   logic                      any_clear;
   hcr_byte_type              host_command_vector;
   hcr_byte_type              host_interface_status;
   logic [31:0]               next_rdata;
   logic                      wr_cmd;
   logic                      wr_ctrl;
   logic                      wr_irq_stat;
   logic                      wr_irq_mask;

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   assign wr_cmd      = i_wr && (i_addr == `HCR_OFS_CMD);
   assign wr_ctrl     = i_wr && (i_addr == `HCR_OFS_CTRL);
   assign wr_irq_stat = i_wr && (i_addr == `HCR_OFS_IRQ_STAT);
   assign wr_irq_mask = i_wr && (i_addr == `HCR_OFS_IRQ_MASK);

   assign part_clear = i_indiv_reset || i_stop_reset;
   assign any_clear  = i_soft_reset || part_clear;

   // -------------------------------------------------------------------------
   // Command register
   // -------------------------------------------------------------------------
   // The command path sees only the command write, the core acknowledge and
   // the reset pulses, never the data transfer registers
   assign cmd_link.wr       = wr_cmd;
   assign cmd_link.wdata    = i_wdata[7:0];
   assign cmd_link.core_ack = i_core_ack;
   assign cmd_link.clear    = any_clear;

   hcr_cmd u_cmd (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .cmd       (cmd_link)
   );

   assign host_command_vector = {cmd_link.flag, cmd_link.vector};

   // -------------------------------------------------------------------------
   // Core side
   // -------------------------------------------------------------------------
   assign o_command_pending_flag   = cmd_link.flag;
   assign o_command_vector_address = {cmd_link.vector, 1'b0};

   // -------------------------------------------------------------------------
   // Interface control
   // -------------------------------------------------------------------------
   // Request enables and dual mode survive the software-level resets; only
   // the hardware reset returns them to polling
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         interface_control <= `HCR_CTRL_RESET;
      else if (wr_ctrl)
         interface_control <= i_wdata[`HCR_CTRL_BITS-1:0];
   end

   // -------------------------------------------------------------------------
   // Request status and lines
   // -------------------------------------------------------------------------
   assign req_link.tx_enable  = interface_control[`HCR_BIT_TX_ENABLE];
   assign req_link.rx_enable  = interface_control[`HCR_BIT_RX_ENABLE];
   assign req_link.dual       = interface_control[`HCR_BIT_DUAL];
   assign req_link.txe        = i_transmit_empty_flag;
   assign req_link.rxf        = i_receive_full_flag;
   assign req_link.soft_clear = i_soft_reset;
   assign req_link.part_clear = part_clear;

   hcr_req u_req (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .req       (req_link)
   );

   assign o_host_request_line     = req_link.host_line;
   assign o_transmit_request_line = req_link.tx_line;
   assign o_receive_request_line  = req_link.rx_line;

   // Status bit 7 equals whichever output set is active in the present mode
   always_comb
   begin
      host_interface_status                    = 8'h00;
      host_interface_status[`HCR_BIT_REQ_STAT] = req_link.req_stat;
   end

   // -------------------------------------------------------------------------
   // Event status and mask
   // -------------------------------------------------------------------------
   always_comb
   begin
      irq_set                    = `HCR_IRQ_RESET;
      irq_set[`HCR_IRQ_ACCEPT]   = cmd_link.accepted;
      irq_set[`HCR_IRQ_REQ_RISE] = req_link.req_rise;
      irq_set[`HCR_IRQ_REFUSED]  = cmd_link.refused;
      irq_clr                    = wr_irq_stat ? i_wdata[`HCR_IRQ_BITS-1:0] : `HCR_IRQ_RESET;
   end

   // A new event in the clearing cycle is kept
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_stat <= `HCR_IRQ_RESET;
      else
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_mask <= `HCR_IRQ_RESET;
      else if (wr_irq_mask)
         irq_mask <= i_wdata[`HCR_IRQ_BITS-1:0];
   end

   assign o_irq = |(irq_stat & irq_mask);

   // -------------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------------
   // Status is read only: writes to its offset fall through unused
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (i_rd)
      begin
         case (i_addr)
            `HCR_OFS_CMD:      next_rdata = {24'h00_0000, host_command_vector};
            `HCR_OFS_STAT:     next_rdata = {24'h00_0000, host_interface_status};
            `HCR_OFS_CTRL:     next_rdata = {29'h0000_0000, interface_control};
            `HCR_OFS_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
            `HCR_OFS_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
            default:           next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rdata <= 32'h0000_0000;
      else
         o_rdata <= next_rdata;
   end

endmodule : hcr_top

// ### verif/hcr_monitor.sv
// Port-level checker for the host command block
`timescale 1ns/10ps

module hcr_monitor
(
   // Clock and reset
   input wire logic        i_clk_sys,
   input wire logic        i_reset_n,
   input wire logic        i_soft_reset,
   input wire logic        i_indiv_reset,
   input wire logic        i_stop_reset,
   // Register port
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   // Data path, core and request lines
   input wire logic        i_receive_full_flag,
   input wire logic        i_transmit_empty_flag,
   input wire logic        i_core_ack,
   input wire logic        o_command_pending_flag,
   input wire logic [7:0]  o_command_vector_address,
   input wire logic        o_host_request_line,
   input wire logic        o_transmit_request_line,
   input wire logic        o_receive_request_line
);
   logic [2:0] ctl;
   wire        any_rst = i_soft_reset | i_indiv_reset | i_stop_reset;
   wire        req_any = o_host_request_line | o_transmit_request_line | o_receive_request_line;
   wire        cmd_wr  = i_wr && i_addr == 8'h00;

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   // ------------------------------------------------------------------------
   // Shadow of the control register, so request lines can be predicted
   // ------------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         ctl <= 3'h0;
      else if (i_wr && i_addr == 8'h08)
         ctl <= i_wdata[2:0];
   end

   chk_write_take: assert property (cmd_wr && !o_command_pending_flag && !any_rst |=>
      o_command_vector_address == {$past(i_wdata[6:0]), 1'b0} && o_command_pending_flag == $past(i_wdata[7]))
      else $error("command write not taken");
   chk_busy_write: assert property (cmd_wr && o_command_pending_flag && !any_rst |=>
      $stable(o_command_vector_address)) else $error("vector changed while pending");
   chk_pend_hold: assert property (o_command_pending_flag && !i_core_ack && !any_rst |=>
      o_command_pending_flag) else $error("pending dropped without ack");
   chk_ack_clear: assert property (o_command_pending_flag && i_core_ack |=>
      !o_command_pending_flag) else $error("ack did not clear pending");
   chk_reset_vec: assert property (any_rst |=>
      o_command_vector_address == 8'h64 && !o_command_pending_flag) else $error("reset left command");
   chk_status_read: assert property (i_rd && i_addr == 8'h04 |=>
      o_rdata == {24'h0, $past(req_any), 7'h0}) else $error("status read wrong");
   chk_req_follow: assert property (!any_rst |=>
      req_any == $past((ctl[1] & i_transmit_empty_flag) | (ctl[0] & i_receive_full_flag)))
      else $error("request not following enables");
   chk_single_quiet: assert property (!$past(ctl[2]) |->
      !o_transmit_request_line && !o_receive_request_line) else $error("dual line in single mode");
   chk_part_reset: assert property ((i_indiv_reset || i_stop_reset) && !i_soft_reset |=>
      req_any == $past(ctl[1]) && !o_receive_request_line) else $error("partial reset request wrong");
   chk_soft_clear: assert property (i_soft_reset |=> !req_any) else $error("soft reset left request");

   cover property (o_command_pending_flag && i_core_ack);
   cover property (cmd_wr && o_command_pending_flag);
   cover property (o_transmit_request_line && o_receive_request_line);
endmodule : hcr_monitor

// ### verif/hcr_core_model.sv
// Core interrupt controller model that accepts pending host commands
`timescale 1ns/10ps

module hcr_core_model
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset_n,
   input  wire logic       i_pending,
   input  wire logic [7:0] i_delay,
   output logic            o_ack
);
   logic [7:0] wait_cnt;

   // One ack pulse after the chosen delay; delay FF holds a command forever
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wait_cnt <= 8'h00;
         o_ack    <= 1'b0;
      end
      else
      begin
         o_ack <= 1'b0;
         if (!i_pending || o_ack)
            wait_cnt <= 8'h00;
         // Count held at zero while delay FF is chosen, so no wrap-around wait
         else if (i_delay == 8'hFF)
            wait_cnt <= 8'h00;
         else if (wait_cnt == i_delay)
            o_ack <= 1'b1;
         else
            wait_cnt <= wait_cnt + 8'h01;
      end
   end
endmodule : hcr_core_model

// ### verif/testbench.sv
// Self-checking bench for the host command block
`timescale 1ns/10ps

module testbench;
   logic        i_clk_sys = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [2:0]  rst_p = 3'h0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0, i_rd = 1'b0;
   logic        i_receive_full_flag = 1'b0, i_transmit_empty_flag = 1'b0;
   logic [7:0]  delay = 8'hFF;
   logic [31:0] o_rdata;
   logic [7:0]  o_command_vector_address;
   logic        i_core_ack, o_command_pending_flag, o_irq;
   logic        o_host_request_line, o_transmit_request_line, o_receive_request_line;
   wire         i_soft_reset = rst_p[0];
   wire         i_indiv_reset = rst_p[1];
   wire         i_stop_reset = rst_p[2];
   int          error_cnt = 0;
   int          checked = 0;

   always #2 i_clk_sys = ~i_clk_sys;

   hcr_top hcr_top_i (
      .i_clk_sys                (i_clk_sys),
      .i_reset_n                (i_reset_n),
      .i_soft_reset             (i_soft_reset),
      .i_indiv_reset            (i_indiv_reset),
      .i_stop_reset             (i_stop_reset),
      .i_addr                   (i_addr),
      .i_wdata                  (i_wdata),
      .i_wr                     (i_wr),
      .i_rd                     (i_rd),
      .o_rdata                  (o_rdata),
      .i_receive_full_flag      (i_receive_full_flag),
      .i_transmit_empty_flag    (i_transmit_empty_flag),
      .i_core_ack               (i_core_ack),
      .o_command_pending_flag   (o_command_pending_flag),
      .o_command_vector_address (o_command_vector_address),
      .o_host_request_line      (o_host_request_line),
      .o_transmit_request_line  (o_transmit_request_line),
      .o_receive_request_line   (o_receive_request_line),
      .o_irq                    (o_irq)
   );
   hcr_core_model hcr_core_model_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .i_pending(o_command_pending_flag), .i_delay(delay), .o_ack(i_core_ack));

   // ------------------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, s);
         error_cnt++;
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= {24'h0, d};
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk("rdata", e, o_rdata[7:0]);
   endtask : rd

   task automatic flags(input logic rx, input logic tx);
      @(posedge i_clk_sys);
      i_receive_full_flag <= rx;
      i_transmit_empty_flag <= tx;
   endtask : flags

   task automatic pulse(input int k);
      @(posedge i_clk_sys);
      rst_p <= 3'h1 << k;
      @(posedge i_clk_sys);
      rst_p <= 3'h0;
      #1;
   endtask : pulse

   task automatic lines(input logic [2:0] e);
      chk("req_lines", {5'h0, e}, {5'h0, o_host_request_line, o_transmit_request_line, o_receive_request_line});
   endtask : lines

   task automatic wait_ack();
      for (int k = 0; k < 300 && o_command_pending_flag; k++)
         @(posedge i_clk_sys);
      #1;
      chk("pending", 8'h00, {7'h0, o_command_pending_flag});
   endtask : wait_ack

   task automatic tally_and_finish();
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      tick(1);
      chk("vec_addr", 8'h64, o_command_vector_address);
      rd(8'h00, 8'h32);
      rd(8'h04, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h00, 8'h85);
      chk("pending", 8'h01, {7'h0, o_command_pending_flag});
      chk("vec_addr", 8'h0A, o_command_vector_address);
      rd(8'h00, 8'h85);
      wr(8'h00, 8'h7F);
      rd(8'h00, 8'h85);
      delay = 8'h03;
      wait_ack();
      rd(8'h00, 8'h05);
      delay = 8'h00;
      wr(8'h00, 8'hFF);
      chk("vec_addr", 8'hFE, o_command_vector_address);
      wait_ack();
      delay = 8'hFF;
      for (int k = 0; k < 3; k++)
      begin
         wr(8'h00, 8'h81);
         pulse(k);
         chk("pending", 8'h00, {7'h0, o_command_pending_flag});
         rd(8'h00, 8'h32);
      end
      flags(1'b0, 1'b1);
      wr(8'h08, 8'h02);
      tick(1);
      lines(3'b100);
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h80);
      flags(1'b1, 1'b1);
      wr(8'h08, 8'h01);
      tick(1);
      lines(3'b100);
      flags(1'b0, 1'b1);
      tick(2);
      lines(3'b000);
      rd(8'h04, 8'h00);
      flags(1'b1, 1'b1);
      wr(8'h08, 8'h07);
      tick(1);
      lines(3'b011);
      rd(8'h04, 8'h80);
      wr(8'h08, 8'h06);
      tick(1);
      lines(3'b010);
      rd(8'h0C, 8'h07);
      chk("irq", 8'h00, {7'h0, o_irq});
      wr(8'h10, 8'h07);
      chk("irq", 8'h01, {7'h0, o_irq});
      wr(8'h0C, 8'h07);
      chk("irq", 8'h00, {7'h0, o_irq});
      rd(8'h0C, 8'h00);
      flags(1'b0, 1'b0);
      tick(2);
      pulse(2);
      lines(3'b010);
      wr(8'h08, 8'h02);
      tick(1);
      pulse(1);
      lines(3'b100);
      tick(1);
      lines(3'b000);
      flags(1'b0, 1'b1);
      tick(2);
      pulse(0);
      lines(3'b000);
      tally_and_finish();
   end

   initial
   begin
      #10000;
      error_cnt++;
      tally_and_finish();
   end
endmodule : testbench

bind hcr_top hcr_monitor hcr_monitor_i (
   .i_clk_sys                (i_clk_sys),
   .i_reset_n                (i_reset_n),
   .i_soft_reset             (i_soft_reset),
   .i_indiv_reset            (i_indiv_reset),
   .i_stop_reset             (i_stop_reset),
   .i_addr                   (i_addr),
   .i_wdata                  (i_wdata),
   .i_wr                     (i_wr),
   .i_rd                     (i_rd),
   .o_rdata                  (o_rdata),
   .i_receive_full_flag      (i_receive_full_flag),
   .i_transmit_empty_flag    (i_transmit_empty_flag),
   .i_core_ack               (i_core_ack),
   .o_command_pending_flag   (o_command_pending_flag),
   .o_command_vector_address (o_command_vector_address),
   .o_host_request_line      (o_host_request_line),
   .o_transmit_request_line  (o_transmit_request_line),
   .o_receive_request_line   (o_receive_request_line)
);
